// ===== logic/i2c_port_pkg.sv
package i2c_port_pkg;

	localparam logic [6:0] TARGET_ADDR  = 7'h13;
	localparam logic       DIR_READ     = 1'b1;
	localparam logic [7:0] IDX_FIRST    = 8'h80;
	localparam logic [7:0] IDX_LAST     = 8'h90;
	localparam int         REG_COUNT    = 17;
	localparam logic [4:0] SLOT_CMD     = 5'h00;
	localparam logic [4:0] SLOT_ID      = 5'h01;
	localparam logic [4:0] SLOT_RES_HI  = 5'h07;
	localparam logic [4:0] SLOT_RES_LO  = 5'h08;
	localparam logic [7:0] CMD_LOCK     = 8'h80;
	localparam int         CMD_RDY_POS  = 5;
	localparam logic [7:0] CMD_WR_MASK  = 8'h0b;
	localparam logic [7:0] CMD_RESET    = 8'h00;
	// Arbitrary identity value, not tied to any real part
	localparam logic [7:0] ID_VALUE     = 8'h5a;
	localparam logic [3:0] BIT_COUNT    = 4'h8;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'b0000,
		ST_ADDR      = 4'b0001,
		ST_ADDR_ACK  = 4'b0010,
		ST_INDEX     = 4'b0011,
		ST_INDEX_ACK = 4'b0100,
		ST_WDATA     = 4'b0101,
		ST_WDATA_ACK = 4'b0110,
		ST_RDATA     = 4'b0111,
		ST_RDATA_ACK = 4'b1000,
		ST_NACK      = 4'b1001
	} port_state_t;

endpackage

// ===== logic/i2c_line_if.sv
`timescale 1ns/1ps
interface i2c_line_if;
	logic scl_rise;
	logic scl_fall;
	logic sda_bit;
	logic start;
	logic stop;

	modport front
	(
		output scl_rise,
		output scl_fall,
		output sda_bit,
		output start,
		output stop
	);
	modport core
	(
		input scl_rise,
		input scl_fall,
		input sda_bit,
		input start,
		input stop
	);
endinterface

// ===== logic/i2c_line_sampler.sv
`timescale 1ns/1ps
module i2c_line_sampler
(
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	i2c_line_if.front       ev
);
	import i2c_port_pkg::*;

	typedef struct packed {
		logic scl_meta;
		logic scl_sync;
		logic scl_prev;
		logic sda_meta;
		logic sda_sync;
		logic sda_prev;
	} sampler_t;

	sampler_t s_reg;
	sampler_t s_next;

	// Two flops per line, then one more for edge finding
	always_comb
	begin
		s_next          = s_reg;
		s_next.scl_meta = scl_i;
		s_next.scl_sync = s_reg.scl_meta;
		s_next.scl_prev = s_reg.scl_sync;
		s_next.sda_meta = sda_i;
		s_next.sda_sync = s_reg.sda_meta;
		s_next.sda_prev = s_reg.sda_sync;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			s_reg <= '{default: 1'b1};
		else
			s_reg <= s_next;
	end

	assign ev.scl_rise = s_reg.scl_sync & ~s_reg.scl_prev;
	assign ev.scl_fall = ~s_reg.scl_sync & s_reg.scl_prev;
	assign ev.sda_bit  = s_reg.sda_sync;
	assign ev.start    = s_reg.scl_sync & s_reg.scl_prev
			& s_reg.sda_prev & ~s_reg.sda_sync;
	assign ev.stop     = s_reg.scl_sync & s_reg.scl_prev
			& ~s_reg.sda_prev & s_reg.sda_sync;
endmodule

// ===== logic/sensor_i2c_register_port.sv
`timescale 1ns/1ps
module sensor_i2c_register_port
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	input  wire logic        int_i,
	output logic             int_o,
	output logic             int_oe_o,
	input  wire logic        event_req_i,
	input  wire logic        result_valid_i,
	input  wire logic [15:0] result_data_i,
	output logic [7:0]       cmd_o,
	output logic             prox_ready_o,
	output logic             wr_strobe_o,
	output logic [7:0]       wr_index_o,
	output logic [7:0]       wr_data_o
);
	import i2c_port_pkg::*;

	typedef struct packed {
		port_state_t           st;
		logic [3:0]            cnt;
		logic [7:0]            sh;
		logic                  rw;
		logic [7:0]            idx;
		logic                  drv;
		logic                  rdy;
		logic                  int_drv;
		logic                  wr;
		logic [7:0]            wr_idx;
		logic [7:0]            wr_data;
		logic [REG_COUNT-1:0][7:0] bank;
	} port_t;

	port_t r_reg;
	port_t r_next;

	i2c_line_if ev ();

	i2c_line_sampler u_sampler
	(
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.scl_i     (scl_i),
		.sda_i     (sda_i),
		.ev        (ev)
	);

	// Maps a bus index to a bank slot; bit 5 flags a valid index
	function automatic logic [5:0] idx_slot(input logic [7:0] idx);
		logic [7:0] off;
		off = idx - IDX_FIRST;
		if (idx >= IDX_FIRST && idx <= IDX_LAST)
			idx_slot = {1'b1, off[4:0]};
		else
			idx_slot = 6'h00;
	endfunction

	logic [5:0] rd_slot;
	logic [5:0] wr_slot;
	logic [7:0] rd_byte;
	logic       rd_take;
	logic       clear_rdy;

	assign rd_slot = idx_slot(r_reg.idx);
	assign wr_slot = idx_slot(r_reg.idx);

	always_comb
	begin
		rd_byte = 8'h00;
		if (rd_slot[5])
		begin
			if (rd_slot[4:0] == SLOT_CMD)
			begin
				rd_byte = (r_reg.bank[SLOT_CMD] & CMD_WR_MASK) | CMD_LOCK;
				rd_byte[CMD_RDY_POS] = r_reg.rdy;
			end
			else if (rd_slot[4:0] == SLOT_ID)
				rd_byte = ID_VALUE;
			else
				rd_byte = r_reg.bank[rd_slot[4:0]];
		end
	end

	always_comb
	begin
		r_next         = r_reg;
		r_next.wr      = 1'b0;
		r_next.int_drv = event_req_i;
		rd_take        = 1'b0;
		if (result_valid_i)
		begin
			r_next.bank[SLOT_RES_HI] = result_data_i[15:8];
			r_next.bank[SLOT_RES_LO] = result_data_i[7:0];
		end
		unique case (r_reg.st)
			ST_IDLE:
				r_next.drv = 1'b0;
			ST_ADDR, ST_INDEX, ST_WDATA:
			begin
				if (ev.scl_rise)
				begin
					r_next.sh  = {r_reg.sh[6:0], ev.sda_bit};
					r_next.cnt = r_reg.cnt + 4'h1;
				end
				else if (ev.scl_fall && r_reg.cnt == BIT_COUNT)
				begin
					r_next.cnt = 4'h0;
					r_next.drv = 1'b1;
					if (r_reg.st == ST_ADDR)
					begin
						if (r_reg.sh[7:1] == TARGET_ADDR)
						begin
							r_next.rw = r_reg.sh[0];
							r_next.st = ST_ADDR_ACK;
						end
						else
						begin
							r_next.drv = 1'b0;
							r_next.st  = ST_IDLE;
						end
					end
					else if (r_reg.st == ST_INDEX)
					begin
						r_next.idx = r_reg.sh;
						r_next.st  = ST_INDEX_ACK;
					end
					else
					begin
						r_next.st      = ST_WDATA_ACK;
						r_next.wr      = 1'b1;
						r_next.wr_idx  = r_reg.idx;
						r_next.wr_data = r_reg.sh;
						r_next.idx     = r_reg.idx + 8'h01;
						if (wr_slot[5] && wr_slot[4:0] == SLOT_CMD)
							r_next.bank[SLOT_CMD] =
								r_reg.sh & CMD_WR_MASK;
						else if (wr_slot[5] && wr_slot[4:0] != SLOT_ID)
							r_next.bank[wr_slot[4:0]] = r_reg.sh;
					end
				end
			end
			ST_ADDR_ACK:
				if (ev.scl_fall)
				begin
					if (r_reg.rw == DIR_READ)
						rd_take = 1'b1;
					else
					begin
						r_next.drv = 1'b0;
						r_next.st  = ST_INDEX;
					end
				end
			ST_INDEX_ACK, ST_WDATA_ACK:
				if (ev.scl_fall)
				begin
					r_next.drv = 1'b0;
					r_next.st  = ST_WDATA;
				end
			ST_RDATA:
			begin
				if (ev.scl_rise)
					r_next.cnt = r_reg.cnt + 4'h1;
				else if (ev.scl_fall)
				begin
					if (r_reg.cnt == BIT_COUNT)
					begin
						r_next.cnt = 4'h0;
						r_next.drv = 1'b0;
						r_next.st  = ST_RDATA_ACK;
					end
					else
					begin
						r_next.sh  = {r_reg.sh[6:0], 1'b0};
						r_next.drv = ~r_reg.sh[6];
					end
				end
			end
			ST_RDATA_ACK:
				if (ev.scl_rise)
					r_next.st = ev.sda_bit ? ST_NACK : ST_RDATA_ACK;
				else if (ev.scl_fall)
					rd_take = 1'b1;
			ST_NACK:
				r_next.drv = 1'b0;
			default:
			begin
				r_next.drv = 1'b0;
				r_next.st  = ST_IDLE;
			end
		endcase
		if (rd_take)
		begin
			r_next.sh  = rd_byte;
			r_next.drv = ~rd_byte[7];
			r_next.cnt = 4'h0;
			r_next.idx = r_reg.idx + 8'h01;
			r_next.st  = ST_RDATA;
		end
		if (ev.start)
		begin
			r_next.st  = ST_ADDR;
			r_next.cnt = 4'h0;
			r_next.drv = 1'b0;
		end
		else if (ev.stop)
		begin
			r_next.st  = ST_IDLE;
			r_next.drv = 1'b0;
		end
		clear_rdy = rd_take && rd_slot[5]
				&& (rd_slot[4:0] == SLOT_RES_HI
				|| rd_slot[4:0] == SLOT_RES_LO);
		// New result wins over a clear in the same cycle
		if (result_valid_i)
			r_next.rdy = 1'b1;
		else if (clear_rdy)
			r_next.rdy = 1'b0;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			r_reg      <= '0;
			r_reg.st   <= ST_IDLE;
		end
		else
			r_reg <= r_next;
	end

	assign sda_o        = 1'b0;
	assign sda_oe_o     = r_reg.drv;
	assign int_o        = 1'b0;
	assign int_oe_o     = r_reg.int_drv;
	assign cmd_o        = r_reg.bank[SLOT_CMD];
	assign prox_ready_o = r_reg.rdy;
	assign wr_strobe_o  = r_reg.wr;
	assign wr_index_o   = r_reg.wr_idx;
	assign wr_data_o    = r_reg.wr_data;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	sequence seq_addr_done;
		r_reg.st == ST_ADDR && r_reg.cnt == BIT_COUNT && ev.scl_fall
			&& !ev.start && !ev.stop;
	endsequence

	sequence seq_data_done;
		r_reg.st == ST_WDATA && r_reg.cnt == BIT_COUNT && ev.scl_fall
			&& !ev.start && !ev.stop;
	endsequence

	a_pins_only_low: assert property (!sda_o && !int_o)
		else $error("open-drain output driven high");
	a_int_follows_req: assert property
		(event_req_i |=> int_oe_o ##1 (int_oe_o || !$past(event_req_i)))
		else $error("interrupt pin does not follow request");
	a_ack_own_addr: assert property
		(seq_addr_done and (r_reg.sh[7:1] == TARGET_ADDR)
			|=> sda_oe_o && r_reg.st == ST_ADDR_ACK)
		else $error("own address not acknowledged");
	a_foreign_ignored: assert property
		(seq_addr_done and (r_reg.sh[7:1] != TARGET_ADDR)
			|=> !sda_oe_o && r_reg.st == ST_IDLE)
		else $error("foreign address acknowledged");
	a_dir_bit: assert property
		(seq_addr_done and (r_reg.sh[7:1] == TARGET_ADDR)
			|=> r_reg.rw == $past(r_reg.sh[0]))
		else $error("direction bit not taken from address byte");
	a_rdy_cleared: assert property
		(clear_rdy && !result_valid_i ##1 !result_valid_i
			|-> !prox_ready_o ##1 !prox_ready_o)
		else $error("ready flag survives result read");
	a_rdy_set_wins: assert property
		(result_valid_i |=> prox_ready_o)
		else $error("new result lost");
	a_write_lands: assert property
		(seq_data_done and (wr_slot[5] && wr_slot[4:0] > SLOT_ID)
			|=> wr_strobe_o ##0 r_reg.bank[$past(wr_slot[4:0])]
				== wr_data_o)
		else $error("register write not stored");
	a_out_of_range: assert property
		(seq_data_done and !wr_slot[5]
			|=> r_reg.bank == $past(r_reg.bank) || $past(result_valid_i))
		else $error("out-of-range index changed a register");
	a_start_restarts: assert property
		(ev.start |=> r_reg.st == ST_ADDR && r_reg.cnt == 4'h0
			&& !sda_oe_o)
		else $error("start condition not honoured");
endmodule

// ===== tb/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model
(
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_o
);
	// Bus clock rests high and data is released between frames
	initial
	begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// 32 ns cell: data moves mid-low, read just before the fall
	task automatic bit_io(input logic b, output logic r);
		#8 sda_oe_o = ~b;
		#8 scl_o = 1'b1;
		#15 r = sda_i;
		#1 scl_o = 1'b0;
	endtask
	task automatic start();
		#16 sda_oe_o = 1'b0;
		#16 scl_o = 1'b1;
		#16 sda_oe_o = 1'b1;
		#16 scl_o = 1'b0;
	endtask
	task automatic stop();
		#8 sda_oe_o = 1'b1;
		#8 scl_o = 1'b1;
		#16 sda_oe_o = 1'b0;
		#32;
	endtask
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
endmodule

// ===== tb/sensor_i2c_register_port_tb_top.sv
`timescale 1ns/1ps
module sensor_i2c_register_port_tb_top;
	import i2c_port_pkg::*;
	logic        sys_clk_i;
	logic        rst_i;
	logic        scl;
	logic        host_oe;
	logic        sda_oe;
	logic        sda_out;
	logic        int_oe;
	logic        int_out;
	logic        event_req;
	logic        result_valid;
	logic [15:0] result_data;
	logic [7:0]  cmd;
	logic        prox_ready;
	logic        wr_strobe;
	logic [7:0]  wr_index;
	logic [7:0]  wr_data;
	logic [7:0]  last_idx;
	logic [7:0]  last_dat;
	logic [7:0]  r[$];
	int          n_errors = 0;
	int          checks_done = 0;
	int          cycles = 0;
	int          n_wr = 0;
	// Pull-ups on both open-drain lines
	wire         sda = ~host_oe & (~sda_oe | sda_out);
	wire         int_line = ~int_oe | int_out;

	sensor_i2c_register_port dut
	(
		.sys_clk_i      (sys_clk_i),
		.rst_i          (rst_i),
		.scl_i          (scl),
		.sda_i          (sda),
		.sda_o          (sda_out),
		.sda_oe_o       (sda_oe),
		.int_i          (int_line),
		.int_o          (int_out),
		.int_oe_o       (int_oe),
		.event_req_i    (event_req),
		.result_valid_i (result_valid),
		.result_data_i  (result_data),
		.cmd_o          (cmd),
		.prox_ready_o   (prox_ready),
		.wr_strobe_o    (wr_strobe),
		.wr_index_o     (wr_index),
		.wr_data_o      (wr_data)
	);
	i2c_host_model host
	(
		.sda_i    (sda),
		.scl_o    (scl),
		.sda_oe_o (host_oe)
	);

	initial
	begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (wr_strobe === 1'b1)
		begin
			n_wr++;
			last_idx = wr_index;
			last_dat = wr_data;
		end
		if (cycles == 30000)
		begin
			n_errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (n_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string m);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] ab, input logic [7:0] idx,
		input logic [7:0] q[$], input logic exp_ack);
		logic a;
		host.start();
		host.wr_byte(ab, a);
		chk(8'(a), 8'(exp_ack), "address ack");
		if (a)
		begin
			host.wr_byte(idx, a);
			foreach (q[i])
				host.wr_byte(q[i], a);
			chk(8'(a), 8'h01, "data ack");
		end
		host.stop();
	endtask

	task automatic rd(input logic [7:0] idx, input int n);
		logic [7:0] d;
		logic a;
		r = {};
		host.start();
		host.wr_byte(8'h26, a);
		host.wr_byte(idx, a);
		host.start();
		host.wr_byte(8'h27, a);
		chk(8'(a), 8'h01, "read address ack");
		for (int i = 0; i < n; i++)
		begin
			host.rd_byte(i == n - 1, d);
			r.push_back(d);
		end
		host.stop();
	endtask

	task automatic pulse_result(input logic [15:0] v);
		@(posedge sys_clk_i);
		result_data <= v;
		result_valid <= 1'b1;
		@(posedge sys_clk_i);
		result_valid <= 1'b0;
		@(posedge sys_clk_i);
		#1;
	endtask

	task automatic t_reset();
		chk(cmd, CMD_RESET, "cmd after reset");
		chk(8'(prox_ready), 8'h00, "ready after reset");
		chk(8'(sda_oe), 8'h00, "sda idle");
		chk(8'(int_oe), 8'h00, "int idle");
	endtask

	task automatic t_foreign();
		int n0;
		n0 = n_wr;
		wr(8'h24, IDX_FIRST, {8'h01}, 1'b0);
		wr(8'ha6, IDX_FIRST, {8'h01}, 1'b0);
		chk(8'(n_wr - n0), 8'h00, "foreign write taken");
	endtask

	task automatic t_burst();
		logic [7:0] q[$];
		logic [7:0] e;
		int n0;
		n0 = n_wr;
		for (int i = 0; i < REG_COUNT; i++)
			q.push_back(8'h3f - 8'(i));
		wr(8'h26, IDX_FIRST, q, 1'b1);
		chk(8'(n_wr - n0), 8'(REG_COUNT), "strobe count");
		chk(last_idx, IDX_LAST, "last index");
		chk(last_dat, 8'h2f, "last data");
		chk(cmd, 8'h3f & CMD_WR_MASK, "cmd bits");
		rd(IDX_FIRST, REG_COUNT);
		for (int i = 0; i < REG_COUNT; i++)
		begin
			e = (i == 0) ? (CMD_LOCK | (q[i] & CMD_WR_MASK)) : q[i];
			e = (i == 1) ? ID_VALUE : e;
			chk(r[i], e, "burst read");
		end
	endtask

	task automatic t_outside();
		wr(8'h26, 8'h91, {8'h55}, 1'b1);
		chk(last_idx, 8'h91, "outside index");
		rd(8'h91, 1);
		chk(r[0], 8'h00, "outside read");
		rd(IDX_LAST, 1);
		chk(r[0], 8'h2f, "last reg kept");
	endtask

	task automatic t_ready();
		pulse_result(16'hbe1d);
		chk(8'(prox_ready), 8'h01, "ready set");
		rd(IDX_FIRST, 1);
		chk(r[0], 8'hab, "ready in cmd");
		rd(8'h89, 1);
		chk(8'(prox_ready), 8'h01, "ready kept");
		rd(8'h87, 1);
		chk(r[0], 8'hbe, "result high");
		chk(8'(prox_ready), 8'h00, "ready cleared high");
		pulse_result(16'h3c77);
		rd(8'h88, 1);
		chk(r[0], 8'h77, "result low");
		chk(8'(prox_ready), 8'h00, "ready cleared low");
	endtask

	task automatic t_int();
		@(posedge sys_clk_i);
		event_req <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk(8'(int_oe), 8'h01, "int pulls");
		chk(8'(int_line), 8'h00, "int line low");
		@(posedge sys_clk_i);
		event_req <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk(8'(int_line), 8'h01, "int released");
	endtask

	initial
	begin
		rst_i = 1'b1;
		event_req = 1'b0;
		result_valid = 1'b0;
		result_data = 16'h0000;
		repeat (12) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		repeat (8) @(posedge sys_clk_i);
		// Keep every bus pin change off the sampling edge
		#1;
		t_reset();
		t_foreign();
		t_burst();
		t_outside();
		t_ready();
		t_int();
		finish_test();
	end
endmodule
